// *** hdl/host_address_decoder.v ***
// host address decoder for RAM, boot ROM and io windows
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "host_address_decoder_defines.vh"
module host_address_decoder
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // host bus
  input wire [19:0] host_addr,
  input wire aen,
  input wire mem_rd_n,
  input wire mem_wr_n,
  input wire io_rd_n,
  input wire io_wr_n,
  // straps
  input wire [4:0] mem_window_strap,
  input wire [2:0] io_window_strap,
  input wire boot_rom_decode_en_n,
  input wire rom_16k_mode,
  // decode outputs
  output reg ram_select,
  output reg io_select,
  output reg boot_rom_select_n,
  output reg low_byte_xcvr_dir_n,
  output reg chrdy_enable
);

  ////////////////////////////////////////////////////////////////
  // strap to segment code (address bits 19..14)
  function [5:0] seg_code;
    input [2:0] s;
    begin
      case (s)
        3'h0: seg_code = `SEG_C0000;
        3'h1: seg_code = `SEG_C4000;
        3'h2: seg_code = `SEG_CC000;
        3'h3: seg_code = `SEG_D0000;
        3'h4: seg_code = `SEG_D4000;
        3'h5: seg_code = `SEG_D8000;
        3'h6: seg_code = `SEG_DC000;
        default: seg_code = `SEG_E0000;
      endcase
    end
  endfunction

  // io strap to address bits 11..4
  function [7:0] io_code;
    input [2:0] s;
    begin
      case (s)
        3'h0: io_code = `IO_260;
        3'h1: io_code = `IO_290;
        3'h2: io_code = `IO_2E0;
        3'h3: io_code = `IO_2F0;
        3'h4: io_code = `IO_300;
        3'h5: io_code = `IO_350;
        3'h6: io_code = `IO_380;
        default: io_code = `IO_3E0;
      endcase
    end
  endfunction

  // strap to nine-bit RAM match for address bits 19..11
  function [8:0] ram_code;
    input [4:0] s;
    begin
      ram_code = {seg_code(s[4:2]), 1'h0, s[1:0]};
    end
  endfunction

  // strap to seven-bit ROM match for address bits 19..13
  function [6:0] rom_code;
    input [4:0] s;
    begin
      rom_code = {seg_code(s[4:2]), 1'h1};
    end
  endfunction

  // io strap to twelve-bit match for address bits 15..4
  function [11:0] io_code12;
    input [2:0] s;
    begin
      io_code12 = {4'h0, io_code(s)};
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // two-stage synchronisers: only the second stage is read
  reg [19:0] addr1_reg;
  reg [19:0] addr2_reg;
  // host address synchroniser
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      addr1_reg <= `ADDR_RESET;
      addr2_reg <= `ADDR_RESET;
    end
    else
    begin
      addr1_reg <= host_addr;
      addr2_reg <= addr1_reg;
    end
  end

  reg [4:0] stb1_reg;
  reg [4:0] stb2_reg;
  // strobe and aen synchroniser, idle while in reset
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      stb1_reg <= `STROBE_RESET;
      stb2_reg <= `STROBE_RESET;
    end
    else
    begin
      stb1_reg <= {io_wr_n, io_rd_n, mem_wr_n, mem_rd_n, aen};
      stb2_reg <= stb1_reg;
    end
  end

  reg [9:0] strap1_reg;
  reg [9:0] strap2_reg;
  // strap synchroniser, boot ROM off while in reset
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      strap1_reg <= `STRAP_RESET;
      strap2_reg <= `STRAP_RESET;
    end
    else
    begin
      strap1_reg <= {rom_16k_mode, boot_rom_decode_en_n, io_window_strap,
        mem_window_strap};
      strap2_reg <= strap1_reg;
    end
  end

  // synchronised views of the pins
  wire [19:0] a = addr2_reg;
  wire aen_s = stb2_reg[0];
  wire mrd_n = stb2_reg[1];
  wire mwr_n = stb2_reg[2];
  wire ird_n = stb2_reg[3];
  wire iwr_n = stb2_reg[4];
  wire [4:0] ms = strap2_reg[4:0];
  wire [2:0] ios = strap2_reg[7:5];
  wire rom_dis = strap2_reg[8];
  wire m16 = strap2_reg[9];

  ////////////////////////////////////////////////////////////////
  // window matches
  wire [8:0] ram_match = ram_code(ms);
  wire [6:0] rom_match = rom_code(ms);
  wire [11:0] io_match = io_code12(ios);
  wire ram_hit = (a[19:11] == ram_match);
  wire rom_hit8 = (a[19:13] == rom_match);
  wire rom_hit16 = (a[19:14] == seg_code(ms[4:2]));
  wire rom_hit = (m16 ? rom_hit16 : rom_hit8) & ~rom_dis;
  wire io_hit = (a[15:4] == io_match);

  // cycle qualification from the synchronised strobes
  wire mem_cyc = ~mrd_n | ~mwr_n;
  wire io_cyc = ~aen_s & (~ird_n | ~iwr_n);
  wire rom_claim = mem_cyc & rom_hit;
  wire ram_claim = mem_cyc & ram_hit & ~(m16 & rom_hit);
  wire io_claim = io_cyc & io_hit;

  ////////////////////////////////////////////////////////////////
  // next values of the decode outputs
  reg ram_select_next;
  reg io_select_next;
  reg boot_rom_select_n_next;
  reg low_byte_xcvr_dir_n_next;
  reg chrdy_enable_next;
  // each claim drives its select, ready and, on reads, the direction
  always @*
  begin
    ram_select_next = 1'h0;
    io_select_next = 1'h0;
    boot_rom_select_n_next = 1'h1;
    low_byte_xcvr_dir_n_next = 1'h1;
    chrdy_enable_next = 1'h0;
    if (rom_claim)
    begin
      boot_rom_select_n_next = 1'h0;
      chrdy_enable_next = 1'h1;
      low_byte_xcvr_dir_n_next = low_byte_xcvr_dir_n_next & mrd_n;
    end
    if (ram_claim)
    begin
      ram_select_next = 1'h1;
      chrdy_enable_next = 1'h1;
      low_byte_xcvr_dir_n_next = low_byte_xcvr_dir_n_next & mrd_n;
    end
    if (io_claim)
    begin
      io_select_next = 1'h1;
      chrdy_enable_next = 1'h1;
      low_byte_xcvr_dir_n_next = low_byte_xcvr_dir_n_next & ird_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered decode outputs
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      ram_select <= 1'h0;
      io_select <= 1'h0;
      boot_rom_select_n <= 1'h1;
      low_byte_xcvr_dir_n <= 1'h1;
      chrdy_enable <= 1'h0;
    end
    else
    begin
      ram_select <= ram_select_next;
      io_select <= io_select_next;
      boot_rom_select_n <= boot_rom_select_n_next;
      low_byte_xcvr_dir_n <= low_byte_xcvr_dir_n_next;
      chrdy_enable <= chrdy_enable_next;
    end
  end

endmodule // host_address_decoder

// *** hdl/host_address_decoder_defines.vh ***
// constants for the host address decoder
`ifndef HOST_ADDRESS_DECODER_DEFINES_VH
`define HOST_ADDRESS_DECODER_DEFINES_VH
`define ADDR_RESET 20'h00000
`define STROBE_RESET 5'h1F
`define STRAP_RESET 10'h100
`define SEG_C0000 6'h30
`define SEG_C4000 6'h31
`define SEG_CC000 6'h33
`define SEG_D0000 6'h34
`define SEG_D4000 6'h35
`define SEG_D8000 6'h36
`define SEG_DC000 6'h37
`define SEG_E0000 6'h38
`define IO_260 8'h26
`define IO_290 8'h29
`define IO_2E0 8'h2E
`define IO_2F0 8'h2F
`define IO_300 8'h30
`define IO_350 8'h35
`define IO_380 8'h38
`define IO_3E0 8'h3E
`endif

// *** tb/host_bus_model.sv ***
// host bus model: turns a cycle kind into bus strobes
`timescale 1ns/1ps
module host_bus_model
(
  // clock and kind: 1 mem read, 2 io read, 3 dma
  input wire logic clk,
  input wire logic [1:0] kind,
  // strobes, idle at time zero
  output logic mem_rd_n = 1'h1,
  output logic io_rd_n = 1'h1,
  output logic aen = 1'h1
);
  // strobes move just after the edge and hold while kind holds
  always_ff @(posedge clk)
  begin
    mem_rd_n <= kind != 2'h1;
    io_rd_n <= kind < 2'h2;
    aen <= kind == 2'h3;
  end
endmodule // host_bus_model

// *** tb/host_address_decoder_asserts.sv ***
// checker for the host address decoder outputs
`timescale 1ns/1ps
module hd_chk
(
  // host bus and straps
  input wire clk, resetn, aen, mem_rd_n, mem_wr_n, rom_16k_mode,
  input wire [19:0] host_addr,
  input wire [4:0] mem_window_strap,
  input wire boot_rom_decode_en_n,
  // decode outputs
  input wire ram_select, io_select, boot_rom_select_n, low_byte_xcvr_dir_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_aen; $past(aen,3) |-> !io_select; endproperty
  a_aen: assert property (p_aen) else $error("io hit with aen");
  property p_off; $past(boot_rom_decode_en_n,3) |-> boot_rom_select_n;
  endproperty
  a_off: assert property (p_off) else $error("rom while off");
  property p_hi; !boot_rom_select_n |-> $past(host_addr[13]|rom_16k_mode,3);
  endproperty
  a_hi: assert property (p_hi) else $error("rom in low half");
  property p_lo; ram_select |-> !$past(host_addr[13],3); endproperty
  a_lo: assert property (p_lo) else $error("ram in high half");
  property p_blk; ram_select |->
    $past(host_addr[12:11]==mem_window_strap[1:0],3); endproperty
  a_blk: assert property (p_blk) else $error("ram block");
  property p_stb; ram_select |-> !$past(mem_rd_n&mem_wr_n,3); endproperty
  a_stb: assert property (p_stb) else $error("ram no strobe");
  property p_io; io_select |-> $past(host_addr[15:9]==7'h01,3); endproperty
  a_io: assert property (p_io) else $error("io range");
  property p_dir; !boot_rom_select_n && $past(!mem_rd_n,3) |->
    !low_byte_xcvr_dir_n; endproperty
  a_dir: assert property (p_dir) else $error("rom read dir");
endmodule // hd_chk
bind host_address_decoder hd_chk u_chk (.*);

// *** tb/host_address_decoder_tb_top.sv ***
// bench for the host address decoder
`timescale 1ns/1ps
module host_address_decoder_tb_top;
  logic clk = 0, resetn = 0, en_n = 0, m16 = 0, mrd, ird, aen, x;
  logic ram, io, rom_n, dir_n, rdy;
  logic [1:0] kind = 0;
  logic [2:0] ios = 0;
  logic [4:0] ms = 0;
  logic [19:0] addr = 0;
  int fail_count = 0, n_checks = 0;
  logic [11:0] iob [8] = '{12'h026, 12'h029, 12'h02E, 12'h02F,
    12'h030, 12'h035, 12'h038, 12'h03E};
  // rows: strap, io strap, kind, address, ram io rom_n
  logic [32:0] rows [6] = '{{5'h00,3'h0,2'h1,20'hC0000,3'h5},
    {5'h1F,3'h0,2'h1,20'hE1800,3'h5}, {5'h00,3'h0,2'h1,20'hC2000,3'h0},
    {5'h01,3'h0,2'h1,20'hC0000,3'h1}, {5'h08,3'h0,2'h1,20'hCE000,3'h0},
    {5'h00,3'h0,2'h3,20'h00260,3'h1}};
  initial forever #50 clk = ~clk;
  host_bus_model host (.clk, .kind, .mem_rd_n(mrd), .io_rd_n(ird), .aen);
  host_address_decoder DUT (.clk, .resetn, .host_addr(addr), .aen,
    .mem_rd_n(mrd), .mem_wr_n(1'h1), .io_rd_n(ird), .io_wr_n(1'h1),
    .mem_window_strap(ms), .io_window_strap(ios),
    .boot_rom_decode_en_n(en_n), .rom_16k_mode(m16), .ram_select(ram),
    .io_select(io), .boot_rom_select_n(rom_n),
    .low_byte_xcvr_dir_n(dir_n), .chrdy_enable(rdy));
  task run(input logic [31:0] r);
    @(posedge clk);
    {en_n, m16, ms, ios, kind, addr} <= r;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task chk(input logic [4:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset, table rows, io codes, then rom off and 16K mode
  initial
  begin
    repeat (8) @(posedge clk);
    #1 chk({ram, io, rom_n, dir_n, rdy}, 5'h06);
    @(posedge clk) resetn <= 1;
    foreach (rows[j])
    begin
      run({2'h0, rows[j][32:3]});
      x = rows[j][2] | rows[j][1] | !rows[j][0];
      chk({ram, io, rom_n, dir_n, rdy}, {rows[j][2:0], !x, x});
    end
    foreach (iob[k])
    begin
      run({7'h00, k[2:0], 2'h2, 4'h0, iob[k], 4'hF});
      chk({ram, io, rom_n, dir_n, rdy}, 5'h0D);
    end
    run({2'h2, rows[2][32:3]});
    chk({ram, io, rom_n, dir_n, rdy}, 5'h06);
    run({2'h1, rows[0][32:3]});
    chk({ram, io, rom_n, dir_n, rdy}, 5'h01);
    print_verdict;
  end
endmodule // host_address_decoder_tb_top
